// ---- apd_pkg.sv ----
// Package for the drive command block: register map, status and
// diagnostic encodings, reset values, timing and shared types.
// Assumes a 10 MHz ref_clk and 32-bit Avalon-MM registers at byte addresses.
package apd_pkg;
    // Register byte offsets on the Avalon-MM slave
    localparam logic [5:0] OFS_DATA = 6'h00;
    localparam logic [5:0] OFS_ERROR = 6'h04;
    localparam logic [5:0] OFS_SECCOUNT = 6'h08;
    localparam logic [5:0] OFS_SECNUM = 6'h0c;
    localparam logic [5:0] OFS_CYLLO = 6'h10;
    localparam logic [5:0] OFS_CYLHI = 6'h14;
    localparam logic [5:0] OFS_DRVHEAD = 6'h18;
    localparam logic [5:0] OFS_STATCMD = 6'h1c;
    localparam logic [5:0] OFS_CONFIG = 6'h20;
    localparam logic [5:0] OFS_FMTSTAT = 6'h24;
    // Status bit positions
    localparam int ST_BSY = 7;
    localparam int ST_DRDY = 6;
    localparam int ST_DRQ = 3;
    localparam int ST_ERR = 0;
    // Drive select bit in drive/head
    localparam int DH_DRV = 4;
    // Config field positions
    localparam int CFG_STANDBY = 0;
    localparam int CFG_PEER = 1;
    localparam int CFG_SECOND = 2;
    localparam int CFG_CODE_LSB = 8;
    // Command codes
    localparam logic [7:0] CMD_POWER = 8'h98;
    localparam logic [7:0] CMD_DIAG = 8'h90;
    localparam logic [7:0] CMD_FORMAT = 8'h50;
    localparam logic [7:0] CMD_IDENT = 8'hec;
    // Power mode answers
    localparam logic [7:0] PWR_STANDBY = 8'h00;
    localparam logic [7:0] PWR_IDLE = 8'hff;
    // Diagnostic codes
    localparam logic [7:0] DIAG_OK = 8'h00;
    localparam logic [7:0] DIAG_FORMATTER = 8'h02;
    localparam logic [7:0] DIAG_BUFFER = 8'h03;
    localparam logic [7:0] DIAG_ECC = 8'h04;
    localparam logic [7:0] DIAG_CPU = 8'h05;
    localparam logic [7:0] DIAG_PEER_FAIL = 8'h80;
    // Format descriptors
    localparam logic [7:0] FMT_GOOD = 8'h00;
    localparam logic [7:0] FMT_UNASSIGN = 8'h20;
    localparam logic [7:0] FMT_ASSIGN = 8'h40;
    localparam logic [7:0] FMT_BAD = 8'h80;
    // Identify block word indices
    localparam logic [7:0] IDW_CONFIG = 8'h00;
    localparam logic [7:0] IDW_CYL = 8'h01;
    localparam logic [7:0] IDW_HEADS = 8'h03;
    localparam logic [7:0] IDW_SECTORS = 8'h06;
    localparam logic [7:0] IDW_SERIAL = 8'h0a;
    localparam logic [7:0] IDW_BUFSIZE = 8'h15;
    localparam logic [7:0] IDW_MODEL = 8'h1b;
    localparam int SERIAL_WORDS = 10;
    localparam int MODEL_WORDS = 20;
    // Reset values
    localparam logic [7:0] RST_STATUS = 8'h40;
    localparam logic [15:0] RST_CONFIG = 16'h0000;
    localparam logic [7:0] RST_ERROR = 8'h01;
    // Timing
    localparam int CLK_HZ = 10_000_000;
    localparam int DIAG_WAIT_S = 5;
    localparam int DIAG_WAIT_CYCLES = DIAG_WAIT_S * CLK_HZ;
    localparam int BUF_WORDS = 256;

    // Sector named by a format that the media should zero
    typedef struct packed {
        logic [15:0] cylinder;
        logic [7:0] sector;
    } apd_zero_t;
endpackage

// ---- apd_cmd_core.sv ----
// Device-side command engine: check power mode, drive diagnostic with
// peer handshake, format track and identify, behind Avalon-MM registers.
// Assumes a single 10 MHz ref_clk; pdiag pin is asynchronous to it.
//
// Decided for this implementation: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module apd_cmd_core #(
    parameter int DIAG_WAIT_CYCLES = apd_pkg::DIAG_WAIT_CYCLES,
    parameter logic [15:0] GEN_CONFIG = 16'h0040,
    parameter logic [15:0] CYLINDERS = 16'h0400,
    parameter logic [15:0] HEADS = 16'h0008,
    parameter logic [15:0] SECTORS = 16'h0020,
    parameter logic [15:0] BUF_UNITS = 16'h0010,
    parameter logic [159:0] SERIAL_TEXT = "SN0000000000000000A1",
    parameter logic [319:0] MODEL_TEXT =
        "GENERIC DRIVE MODEL 0000000000000000000A"
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Avalon-MM slave
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Drive pins
    output logic intrq,
    input wire logic pdiagIn,
    output logic pdiagOut,
    output logic pdiagOe,
    // Media zero-fill requests
    output logic zeroReq,
    output apd_pkg::apd_zero_t zeroTarget
);
    typedef enum logic [2:0] {
        S_IDLE, S_POWER, S_DIAG, S_FMT_FILL, S_FMT_RUN, S_ID_FILL, S_ID_XFER
    } apd_state_t;

    function automatic logic [15:0] merge16(input logic [15:0] old,
            input logic [15:0] wd, input logic [3:0] be);
        logic [15:0] mask;
        mask = {{8{be[1]}}, {8{be[0]}}};
        merge16 = (old & ~mask) | (wd & mask);
    endfunction

    function automatic logic [15:0] identWord(input logic [7:0] idx);
        logic [7:0] rel;
        identWord = 16'h0000;
        rel = 8'h00;
        if (idx == apd_pkg::IDW_CONFIG) begin
            identWord = GEN_CONFIG;
        end else if (idx == apd_pkg::IDW_CYL) begin
            identWord = CYLINDERS;
        end else if (idx == apd_pkg::IDW_HEADS) begin
            identWord = HEADS;
        end else if (idx == apd_pkg::IDW_SECTORS) begin
            identWord = SECTORS;
        end else if (idx == apd_pkg::IDW_BUFSIZE) begin
            identWord = BUF_UNITS;
        end else if (idx >= apd_pkg::IDW_SERIAL && idx <
                apd_pkg::IDW_SERIAL + 8'(apd_pkg::SERIAL_WORDS)) begin
            rel = idx - apd_pkg::IDW_SERIAL;
            identWord = SERIAL_TEXT[159 - 16 * int'(rel) -: 16];
        end else if (idx >= apd_pkg::IDW_MODEL && idx <
                apd_pkg::IDW_MODEL + 8'(apd_pkg::MODEL_WORDS)) begin
            rel = idx - apd_pkg::IDW_MODEL;
            identWord = MODEL_TEXT[319 - 16 * int'(rel) -: 16];
        end
    endfunction

    // Task-file and control registers
    apd_state_t state;
    logic [7:0] status;
    logic [7:0] errorReg;
    logic [7:0] secCount;
    logic [7:0] secNum;
    logic [7:0] cylLo;
    logic [7:0] cylHi;
    logic [7:0] drvHead;
    logic [15:0] cfgWord;
    logic [7:0] badCount;
    logic [7:0] altCount;
    logic [15:0] fmtCyl;
    logic [8:0] fmtTotal;
    logic [8:0] wordCnt;
    logic [31:0] diagTimer;
    logic [15:0] dataOut;
    logic pdiagMeta;
    logic pdiagSync;
    logic [15:0] buffer [0:apd_pkg::BUF_WORDS-1];

    // Bus decode
    wire logic rdAcc = avs_read & ~avs_waitrequest;
    wire logic wrAcc = avs_write & ~avs_waitrequest;
    wire logic [15:0] wd16 = avs_writedata[15:0];
    wire logic [7:0] wd8 = avs_byteenable[0] ? avs_writedata[7:0] : 8'h00;
    wire logic selData = avs_address == apd_pkg::OFS_DATA;
    wire logic selCmd = avs_address == apd_pkg::OFS_STATCMD;
    wire logic cmdWr = wrAcc & selCmd & avs_byteenable[0];
    wire logic [7:0] cmdCode = avs_writedata[7:0];
    wire logic isSecond = cfgWord[apd_pkg::CFG_SECOND];
    wire logic peerPresent = cfgWord[apd_pkg::CFG_PEER];
    wire logic [7:0] ownCode = cfgWord[apd_pkg::CFG_CODE_LSB +: 8];
    wire logic selected = drvHead[apd_pkg::DH_DRV] == isSecond;
    wire logic dataWr = wrAcc & selData & (state == S_FMT_FILL);
    wire logic dataRd = rdAcc & selData & (state == S_ID_XFER);
    wire logic [7:0] ptr = wordCnt[7:0];
    wire logic bufWe = dataWr | (state == S_ID_FILL);
    wire logic [15:0] bufWData = (state == S_ID_FILL) ? identWord(ptr)
        : merge16(16'h0000, wd16, avs_byteenable);
    wire logic [15:0] fmtWord = buffer[ptr];
    wire logic lastWord = wordCnt == 9'(apd_pkg::BUF_WORDS - 1);
    wire logic diagTimeout = diagTimer >= 32'(DIAG_WAIT_CYCLES - 1);
    wire logic [7:0] diagResult = (pdiagSync | ~peerPresent) ? ownCode
        : (ownCode | apd_pkg::DIAG_PEER_FAIL);
    wire logic [31:0] rdMux =
        selData ? {16'h0000, dataOut} :
        (avs_address == apd_pkg::OFS_ERROR) ? {24'h0, errorReg} :
        (avs_address == apd_pkg::OFS_SECCOUNT) ? {24'h0, secCount} :
        (avs_address == apd_pkg::OFS_SECNUM) ? {24'h0, secNum} :
        (avs_address == apd_pkg::OFS_CYLLO) ? {24'h0, cylLo} :
        (avs_address == apd_pkg::OFS_CYLHI) ? {24'h0, cylHi} :
        (avs_address == apd_pkg::OFS_DRVHEAD) ? {24'h0, drvHead} :
        selCmd ? {24'h0, status} :
        (avs_address == apd_pkg::OFS_CONFIG) ? {16'h0, cfgWord} :
        (avs_address == apd_pkg::OFS_FMTSTAT) ? {16'h0, altCount, badCount}
        : 32'h0000_0000;

    // Pin synchroniser
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pdiagMeta <= 1'b0;
            pdiagSync <= 1'b0;
        end else begin
            pdiagMeta <= ~pdiagIn;
            pdiagSync <= pdiagMeta;
        end
    end

    // Bus handshake: one wait cycle, then the access completes
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end else if ((avs_read | avs_write) & avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
            avs_readdata <= avs_read ? rdMux : 32'h0000_0000;
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end

    // Sector buffer
    always_ff @(posedge ref_clk) begin
        if (bufWe) begin
            buffer[ptr] <= bufWData;
        end
    end

    // Plain task-file registers written by the host
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            secNum <= 8'h00;
            cylLo <= 8'h00;
            cylHi <= 8'h00;
            drvHead <= 8'h00;
            cfgWord <= apd_pkg::RST_CONFIG;
        end else if (wrAcc & avs_byteenable[0]) begin
            if (avs_address == apd_pkg::OFS_SECNUM) begin
                secNum <= wd8;
            end
            if (avs_address == apd_pkg::OFS_CYLLO) begin
                cylLo <= wd8;
            end
            if (avs_address == apd_pkg::OFS_CYLHI) begin
                cylHi <= wd8;
            end
            if (avs_address == apd_pkg::OFS_DRVHEAD) begin
                drvHead <= wd8;
            end
            if (avs_address == apd_pkg::OFS_CONFIG) begin
                cfgWord <= merge16(cfgWord, wd16, avs_byteenable);
            end
        end
    end

    // Interrupt: raised by power, first-drive diagnostic and format completion and by identify data ready, cleared by a status read
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            intrq <= 1'b0;
        end else if (state == S_POWER ||
                (state == S_DIAG && !isSecond &&
                 (pdiagSync || !peerPresent || diagTimeout)) ||
                (state == S_FMT_RUN && wordCnt >= fmtTotal) ||
                (state == S_ID_FILL && lastWord)) begin
            intrq <= 1'b1;
        end else if (rdAcc & selCmd) begin
            intrq <= 1'b0;
        end
    end

    // Command engine
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state <= S_IDLE;
            status <= apd_pkg::RST_STATUS;
            errorReg <= apd_pkg::RST_ERROR;
            secCount <= 8'h01;
            wordCnt <= 9'h000;
            fmtTotal <= 9'h000;
            fmtCyl <= 16'h0000;
            badCount <= 8'h00;
            altCount <= 8'h00;
            diagTimer <= 32'h0000_0000;
            dataOut <= 16'h0000;
            pdiagOut <= 1'b0;
            pdiagOe <= 1'b0;
            zeroReq <= 1'b0;
            zeroTarget <= '0;
        end else begin
            zeroReq <= 1'b0;
            if (cmdWr && cmdCode == apd_pkg::CMD_DIAG) begin
                state <= S_DIAG;
                status <= 8'h80;
                diagTimer <= 32'h0000_0000;
                pdiagOe <= 1'b0;
            end else if (cmdWr && selected &&
                    cmdCode == apd_pkg::CMD_POWER) begin
                state <= S_POWER;
                status <= 8'h80;
            end else if (cmdWr && selected &&
                    cmdCode == apd_pkg::CMD_FORMAT) begin
                state <= S_FMT_FILL;
                status <= 8'h48;
                fmtTotal <= (secCount == 8'h00) ? 9'h100
                    : {1'b0, secCount};
                fmtCyl <= {cylHi, cylLo};
                wordCnt <= 9'h000;
            end else if (cmdWr && selected &&
                    cmdCode == apd_pkg::CMD_IDENT) begin
                state <= S_ID_FILL;
                status <= 8'h80;
                wordCnt <= 9'h000;
            end else if (cmdWr && selected) begin
                state <= S_IDLE;
                status <= 8'h41;
                errorReg <= 8'h04;
            end else if (wrAcc && avs_address == apd_pkg::OFS_SECCOUNT &&
                    avs_byteenable[0]) begin
                secCount <= wd8;
            end else begin
                unique case (state)
                    S_IDLE: begin
                    end
                    S_POWER: begin
                        secCount <= cfgWord[apd_pkg::CFG_STANDBY]
                            ? apd_pkg::PWR_STANDBY
                            : apd_pkg::PWR_IDLE;
                        status <= apd_pkg::RST_STATUS;
                        state <= S_IDLE;
                    end
                    S_DIAG: begin
                        if (isSecond) begin
                            errorReg <= ownCode;
                            pdiagOe <= ownCode == apd_pkg::DIAG_OK;
                            pdiagOut <= 1'b0;
                            status <= apd_pkg::RST_STATUS;
                            state <= S_IDLE;
                        end else if (pdiagSync || !peerPresent ||
                                diagTimeout) begin
                            errorReg <= diagResult;
                            status <= apd_pkg::RST_STATUS;
                            state <= S_IDLE;
                        end else begin
                            diagTimer <= diagTimer + 32'h0000_0001;
                        end
                    end
                    S_FMT_FILL: begin
                        if (dataWr) begin
                            if (lastWord) begin
                                status <= 8'h80;
                                wordCnt <= 9'h000;
                                badCount <= 8'h00;
                                altCount <= 8'h00;
                                state <= S_FMT_RUN;
                            end else begin
                                wordCnt <= wordCnt + 9'h001;
                            end
                        end
                    end
                    S_FMT_RUN: begin
                        if (wordCnt >= fmtTotal) begin
                            status <= apd_pkg::RST_STATUS;
                            state <= S_IDLE;
                        end else begin
                            if (fmtWord[7:0] == apd_pkg::FMT_BAD) begin
                                badCount <= badCount + 8'h01;
                            end
                            if (fmtWord[7:0] == apd_pkg::FMT_ASSIGN) begin
                                altCount <= altCount + 8'h01;
                            end else if (fmtWord[7:0] ==
                                    apd_pkg::FMT_UNASSIGN &&
                                    altCount != 8'h00) begin
                                altCount <= altCount - 8'h01;
                            end
                            zeroReq <= 1'b1;
                            zeroTarget.cylinder <= fmtCyl;
                            zeroTarget.sector <= fmtWord[15:8];
                            wordCnt <= wordCnt + 9'h001;
                        end
                    end
                    S_ID_FILL: begin
                        if (lastWord) begin
                            wordCnt <= 9'h000;
                            dataOut <= buffer[8'h00];
                            status <= 8'h48;
                            state <= S_ID_XFER;
                        end else begin
                            wordCnt <= wordCnt + 9'h001;
                        end
                    end
                    S_ID_XFER: begin
                        if (dataRd) begin
                            if (lastWord) begin
                                status <= apd_pkg::RST_STATUS;
                                state <= S_IDLE;
                            end else begin
                                dataOut <= buffer[8'(wordCnt + 9'h001)];
                                wordCnt <= wordCnt + 9'h001;
                            end
                        end
                    end
                endcase
            end
        end
    end
endmodule

// ---- apd_cmd_core_monitor.sv ----
// Checker for the drive command block, bound onto its top module.
// Assumes the Avalon-MM and drive pins of apd_cmd_core as declared.
`timescale 1ns/1ps
module apd_cmd_core_monitor (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Avalon-MM slave
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // Drive pins
    input wire logic intrq,
    input wire logic pdiagOut,
    input wire logic pdiagOe,
    // Media zero-fill
    input wire logic zeroReq,
    input wire apd_pkg::apd_zero_t zeroTarget
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    wire statRead = avs_read && !avs_waitrequest &&
        avs_address == apd_pkg::OFS_STATCMD;

    chk_wait_drop: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("waitrequest did not drop");
    chk_wait_single: assert property (
        !avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    chk_pdiag_low: assert property (pdiagOe |-> !pdiagOut)
        else $error("pdiag driven high");
    chk_irq_clear: assert property (
        $fell(intrq) |-> $past(statRead))
        else $error("intrq cleared without status read");
    chk_target_hold: assert property (
        !zeroReq |-> $stable(zeroTarget))
        else $error("zero target moved without request");
    chk_upper_zero: assert property (
        avs_readdata[31:16] == 16'h0)
        else $error("upper read data not zero");
    chk_second_quiet: assert property (
        $rose(pdiagOe) |-> !$rose(intrq))
        else $error("second drive raised intrq");
    chk_busy_drq: assert property (
        statRead |-> !(avs_readdata[7] && avs_readdata[3]))
        else $error("busy and drq together");
endmodule

bind apd_cmd_core apd_cmd_core_monitor u_mon (
    .ref_clk(ref_clk), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .intrq(intrq), .pdiagOut(pdiagOut), .pdiagOe(pdiagOe),
    .zeroReq(zeroReq), .zeroTarget(zeroTarget));

// ---- apd_peer_drive.sv ----
// Model of the second drive on the shared pdiag line.
// Assumes the bench pulses go when the diagnostic command is issued.
`timescale 1ns/1ps
module apd_peer_drive (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Control from bench
    input wire logic go,
    input wire logic pass,
    input wire logic [7:0] dly,
    // Open-drain pull on pdiag
    output logic pullLow
);
    logic [7:0] cnt;

    // Runs own diagnostic, pulls line low after dly if it passed
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cnt <= 8'h00;
            pullLow <= 1'b0;
        end else if (go) begin
            cnt <= dly;
            pullLow <= 1'b0;
        end else if (cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
            pullLow <= (cnt == 8'h01) && pass;
        end
    end
endmodule

// ---- apd_cmd_core_tb.sv ----
// Self-checking bench for the drive command block.
// Assumes apd_pkg, the bound checker and the peer drive model.
`timescale 1ns/1ps
module apd_cmd_core_tb;
    localparam logic [159:0] SER = "TB-SERIAL-0000000042";
    localparam logic [319:0] MDL = "TEST MODEL FOR BENCH USE 0123456789ABCDE";
    logic ref_clk, resetn, avs_read, avs_write, intrq, pdiagOut, pdiagOe;
    logic zeroReq, avs_waitrequest, peerGo, peerPass, peerLow;
    logic [5:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [7:0] peerDly;
    logic [15:0] q;
    wire logic pdiagIn;
    apd_pkg::apd_zero_t zeroTarget;
    apd_pkg::apd_zero_t zq[$];
    int fail_count = 0;
    int n_checks = 0;
    logic [7:0] dCode[8] = '{8'h00, 8'h02, 8'h03, 8'h04, 8'h05,
        8'h03, 8'h03, 8'h03};
    int dMode[8] = '{0, 0, 0, 0, 0, 1, 2, 3};
    logic [7:0] fDesc[5] = '{8'h40, 8'h20, 8'h40, 8'h80, 8'h00};

    // Pull-up on the shared line
    assign pdiagIn = !(peerLow || (pdiagOe && !pdiagOut));

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    apd_cmd_core #(.DIAG_WAIT_CYCLES(50), .SERIAL_TEXT(SER),
        .MODEL_TEXT(MDL)) u_dut (
        .ref_clk(ref_clk), .resetn(resetn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .intrq(intrq), .pdiagIn(pdiagIn), .pdiagOut(pdiagOut),
        .pdiagOe(pdiagOe), .zeroReq(zeroReq), .zeroTarget(zeroTarget));

    apd_peer_drive u_peer (.ref_clk(ref_clk), .resetn(resetn),
        .go(peerGo), .pass(peerPass), .dly(peerDly), .pullLow(peerLow));

    always @(posedge ref_clk) begin
        if (zeroReq === 1'b1) zq.push_back(zeroTarget);
    end

    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task bus(input logic r, input logic [5:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        avs_address <= a;
        avs_read <= r;
        avs_write <= !r;
        avs_writedata <= {16'h0, d};
        do begin
            @(posedge ref_clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata[15:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task wr(input logic [5:0] a, input logic [15:0] d);
        bus(1'b0, a, d);
    endtask

    task rdc(input string nm, input logic [5:0] a, input logic [15:0] e);
        bus(1'b1, a, 16'h0);
        chk(nm, e, q);
    endtask

    task wait_irq;
        int n;
        n = 0;
        while (intrq !== 1'b1 && n < 600) begin
            @(posedge ref_clk);
            n++;
        end
        chk("intrq", 16'h1, {15'h0, intrq});
    endtask

    function automatic logic [15:0] idw(input int i);
        if (i == 0) return 16'h0040;
        if (i == 1) return 16'h0400;
        if (i == 3) return 16'h0008;
        if (i == 6) return 16'h0020;
        if (i == 21) return 16'h0010;
        if (i >= 10 && i < 20) return SER[159 - 16 * (i - 10) -: 16];
        if (i >= 27 && i < 47) return MDL[319 - 16 * (i - 27) -: 16];
        return 16'h0;
    endfunction

    task stop_test;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge ref_clk);
        fail_count++;
        stop_test;
    end

    initial begin
        avs_address = 6'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        resetn = 1'b0;
        peerGo = 1'b0;
        peerPass = 1'b0;
        peerDly = 8'h00;
        repeat (10) @(posedge ref_clk);
        resetn <= 1'b1;
        rdc("status", apd_pkg::OFS_STATCMD, 16'h40);
        rdc("error", apd_pkg::OFS_ERROR, 16'h01);
        rdc("unmapped", 6'h3c, 16'h0);
        wr(apd_pkg::OFS_DRVHEAD, 16'h0);
        for (int s = 0; s < 2; s++) begin
            wr(apd_pkg::OFS_CONFIG, 16'(s));
            wr(apd_pkg::OFS_STATCMD, 16'h98);
            wait_irq;
            rdc("seccount", apd_pkg::OFS_SECCOUNT, s ? 16'h0 : 16'hff);
            rdc("status", apd_pkg::OFS_STATCMD, 16'h40);
        end
        for (int i = 0; i < 8; i++) begin
            wr(apd_pkg::OFS_DRVHEAD, {11'h0, i[0], 4'h0});
            wr(apd_pkg::OFS_CONFIG, {dCode[i], 6'h0, dMode[i] != 0, 1'b0});
            peerPass <= dMode[i] != 3;
            peerDly <= dMode[i] == 2 ? 8'd90 : 8'd10;
            peerGo <= 1'b1;
            wr(apd_pkg::OFS_STATCMD, 16'h90);
            peerGo <= 1'b0;
            wait_irq;
            rdc("diag code", apd_pkg::OFS_ERROR, {8'h0, dCode[i] |
                (dMode[i] > 1 ? 8'h80 : 8'h00)});
            if (dMode[i] > 1) wr(apd_pkg::OFS_DRVHEAD, 16'h10);
            rdc("status", apd_pkg::OFS_STATCMD, 16'h40);
        end
        wr(apd_pkg::OFS_DRVHEAD, 16'h0);
        wr(apd_pkg::OFS_CONFIG, 16'h0);
        wr(apd_pkg::OFS_SECCOUNT, 16'h5);
        wr(apd_pkg::OFS_CYLHI, 16'h12);
        wr(apd_pkg::OFS_CYLLO, 16'h34);
        wr(apd_pkg::OFS_STATCMD, 16'h50);
        rdc("fmt drq", apd_pkg::OFS_STATCMD, 16'h48);
        zq.delete();
        for (int i = 0; i < 256; i++)
            wr(apd_pkg::OFS_DATA, i < 5 ? {8'(2 * i + 1), fDesc[i]} : 16'h0);
        wait_irq;
        chk("zero count", 16'h5, 16'(zq.size()));
        for (int i = 0; i < 5; i++) begin
            chk("zero cyl", 16'h1234, zq[i].cylinder);
            chk("zero sec", 16'(2 * i + 1), {8'h0, zq[i].sector});
        end
        rdc("fmt stats", apd_pkg::OFS_FMTSTAT, 16'h0101);
        rdc("status", apd_pkg::OFS_STATCMD, 16'h40);
        wr(apd_pkg::OFS_STATCMD, 16'h91);
        rdc("abort status", apd_pkg::OFS_STATCMD, 16'h41);
        rdc("abort error", apd_pkg::OFS_ERROR, 16'h04);
        wr(apd_pkg::OFS_STATCMD, 16'hec);
        wait_irq;
        rdc("id drq", apd_pkg::OFS_STATCMD, 16'h48);
        for (int i = 0; i < 256; i++)
            rdc("id word", apd_pkg::OFS_DATA, idw(i));
        rdc("status", apd_pkg::OFS_STATCMD, 16'h40);
        wr(apd_pkg::OFS_CONFIG, 16'h0004);
        wr(apd_pkg::OFS_STATCMD, 16'h90);
        repeat (5) @(posedge ref_clk);
        chk("pdiag drive", 16'h1, {15'h0, pdiagOe});
        chk("pdiag level", 16'h0, {15'h0, pdiagOut});
        chk("second irq", 16'h0, {15'h0, intrq});
        resetn <= 1'b0;
        repeat (2) @(posedge ref_clk);
        chk("pdiag reset", 16'h0, {15'h0, pdiagOe});
        resetn <= 1'b1;
        rdc("status", apd_pkg::OFS_STATCMD, 16'h40);
        stop_test;
    end
endmodule
